// ---- common/sadc_regs.vh ----
`ifndef SADC_REGS_VH
`define SADC_REGS_VH

// register byte offsets
`define SADC_CTRL_OFS 8'h00
`define SADC_STAT_OFS 8'h04
`define SADC_RSLT_OFS 8'h08

// control field positions and reset value
`define SADC_CTRL_CSS_BIT 0
`define SADC_CTRL_PWD_BIT 1
`define SADC_CTRL_FMT_BIT 2
`define SADC_CTRL_RST 3'h0

// status and result field positions
`define SADC_STAT_BUSY_BIT 0
`define SADC_STAT_READ_BIT 1
`define SADC_STAT_EMPTY_BIT 2
`define SADC_STAT_FULL_BIT 3
`define SADC_RSLT_VALID_BIT 16

// AXI responses
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_SLVERR 2'h2

// word layout
`define SADC_RES_W 12
`define SADC_WORD_W 16
`define SADC_BITS_PER_WORD 5'h10
`define SADC_MSB_FLIP 12'h800

// timing
`define SADC_MCLK_NS 10
`define SADC_TC1_NS 110
`define SADC_TD4_NS 270
`define SADC_TC1_CYC ((`SADC_TC1_NS + `SADC_MCLK_NS - 1) / `SADC_MCLK_NS)
`define SADC_HALF_CYC ((`SADC_TC1_CYC + 1) / 2)
`define SADC_TD4_CYC ((`SADC_TD4_NS + `SADC_MCLK_NS - 1) / `SADC_MCLK_NS)
`define SADC_CONV_CYC 300

`endif

// ---- logic/sadc_ctrl.v ----
// Function
// - select bit picks external or internal shift clock
// - internal mode sends result with 16 clock pulses
// - select low, convert fall starts a conversion
// - internal mode: same fall starts sending prior result
// - external mode read starts when select is low and convert is high
// - sync pulse only after clock seen outside read
// - power-down refuses conversion starts
// - power-down keeps last result readable
// - format bit picks straight binary or two's complement on the serial output
// - cascade input passes through to serial output
// - busy low from start until result loaded
// - select and convert ORed, last edge acts
// - after 16 bits, output shows cascade input, latched at burst start in internal mode
// - internal clock held low after its burst
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "sadc_regs.vh"

module sadc_sync #(
  parameter W = 1
)
(
  input wire clk,
  input wire resetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_ff;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

module sadc_fifo #(
  parameter W = 12,
  parameter DEPTH = 8,
  parameter AW = 3
)
(
  input wire clk,
  input wire resetn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wptr_ff;
  reg [AW:0] rptr_ff;
  wire empty = (wptr_ff == rptr_ff);
  wire full = (wptr_ff[AW] != rptr_ff[AW]) &&
    (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rptr_ff[AW-1:0]];

  always @(posedge clk)
  begin
    if (in_valid && !full)
      mem[wptr_ff[AW-1:0]] <= in_data;
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr_ff <= {(AW+1){1'b0}};
      rptr_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
        wptr_ff <= wptr_ff + 1'b1;
      if (out_ready && !empty)
        rptr_ff <= rptr_ff + 1'b1;
    end
  end
endmodule

module sadc_ctrl #(
  parameter CONV_CYCLES = `SADC_CONV_CYC,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
)
(
  input wire mclk,
  input wire resetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire read_convert,
  input wire dev_select_n,
  input wire cascade_in,
  input wire data_shift_clock_in,
  output reg data_shift_clock_out,
  output reg data_shift_clock_oe,
  output reg serial_data,
  output reg frame_sync,
  output reg busy_n,
  input wire [11:0] sar_code
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_IWAIT = 5'b00010;
  localparam ST_IHI = 5'b00100;
  localparam ST_ILO = 5'b01000;
  localparam ST_XRD = 5'b10000;
  localparam integer CONV_LAST_I = CONV_CYCLES - 1;
  localparam integer TD4_I = `SADC_TD4_CYC;
  localparam integer HALF_I = `SADC_HALF_CYC;
  localparam [15:0] CONV_LAST = CONV_LAST_I[15:0];
  localparam [4:0] TD4 = TD4_I[4:0];
  localparam [4:0] HALF = HALF_I[4:0];

  reg [2:0] ctrl_ff;
  reg [4:0] st_ff;
  reg [4:0] tcnt_ff;
  reg [4:0] bitcnt_ff;
  reg [15:0] tx_sr_ff;
  reg [15:0] conv_cnt_ff;
  reg [11:0] result_ff;
  reg conv_busy_ff;
  reg push_ff;
  reg tag_lat_ff;
  reg seen_ff;
  reg sync_pend_ff;
  reg shown_ff;
  reg sel_n_d_ff;
  reg rd_sel_d_ff;
  reg dclk_d_ff;
  wire rc_s;
  wire cs_n_s;
  wire dclk_s;
  wire tag_s;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [11:0] fifo_out_data;
  wire ext_mode = ctrl_ff[`SADC_CTRL_CSS_BIT];
  wire pwd = ctrl_ff[`SADC_CTRL_PWD_BIT];
  wire fmt_sb = ctrl_ff[`SADC_CTRL_FMT_BIT];

  // no gating on the raw pins: edges come only from the second flop
  sadc_sync #(.W(4)) u_sync (
    .clk(mclk),
    .resetn(resetn),
    .d({read_convert, dev_select_n, data_shift_clock_in, cascade_in}),
    .q({rc_s, cs_n_s, dclk_s, tag_s})
  );

  wire sel_n = cs_n_s | rc_s;
  wire conv_fall = sel_n_d_ff & !sel_n;
  wire rd_sel = !cs_n_s & rc_s;
  wire rd_rise = rd_sel & !rd_sel_d_ff;
  wire dclk_rise = dclk_s & !dclk_d_ff;
  // a full fifo stalls new conversions instead of losing results
  wire conv_go = conv_fall & !conv_busy_ff & !pwd & fifo_in_ready;
  // sign flip of the msb turns the offset code into two's complement
  wire [11:0] fmt_code = fmt_sb ? result_ff :
    (result_ff ^ `SADC_MSB_FLIP);
  wire [15:0] tx_word = {fmt_code, 4'h0};

  // AXI handshake decode
  wire wr_go = s_axi_awvalid & s_axi_wvalid & !s_axi_awready &
    !s_axi_bvalid;
  wire rd_go = s_axi_arvalid & !s_axi_arready & !s_axi_rvalid;
  wire fifo_pop = rd_go & (s_axi_araddr == `SADC_RSLT_OFS);

  sadc_fifo #(.W(`SADC_RES_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(mclk),
    .resetn(resetn),
    .in_valid(push_ff),
    .in_ready(fifo_in_ready),
    .in_data(result_ff),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SADC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SADC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      ctrl_ff <= `SADC_CTRL_RST;
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      s_axi_arready <= rd_go;
      if (wr_go)
      begin
        if (s_axi_awaddr == `SADC_CTRL_OFS)
        begin
          s_axi_bresp <= `SADC_RESP_OKAY;
          if (s_axi_wstrb[0])
            ctrl_ff <= s_axi_wdata[2:0];
        end
        else if (s_axi_awaddr == `SADC_STAT_OFS ||
          s_axi_awaddr == `SADC_RSLT_OFS)
          s_axi_bresp <= `SADC_RESP_OKAY;
        else
          s_axi_bresp <= `SADC_RESP_SLVERR;
      end
      // answers only after the request handshake edge
      if (s_axi_awready)
        s_axi_bvalid <= 1'b1;
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go)
      begin
        s_axi_rresp <= `SADC_RESP_OKAY;
        case (s_axi_araddr)
          `SADC_CTRL_OFS:
            s_axi_rdata <= {29'h00000000, ctrl_ff};
          `SADC_STAT_OFS:
            s_axi_rdata <= {28'h0000000, !fifo_in_ready, !fifo_out_valid,
              !st_ff[0], conv_busy_ff};
          `SADC_RSLT_OFS:
            s_axi_rdata <= {15'h0000, fifo_out_valid, 4'h0,
              fifo_out_data};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SADC_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_arready)
        s_axi_rvalid <= 1'b1;
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // conversion timer; power-down stops new starts, but a running conversion still loads its result
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      conv_busy_ff <= 1'b0;
      conv_cnt_ff <= 16'h0000;
      result_ff <= 12'h000;
      push_ff <= 1'b0;
      busy_n <= 1'b1;
      // low: syncs reset low, a high here would fake a start
      sel_n_d_ff <= 1'b0;
      rd_sel_d_ff <= 1'b0;
      dclk_d_ff <= 1'b0;
    end
    else
    begin
      sel_n_d_ff <= sel_n;
      rd_sel_d_ff <= rd_sel;
      dclk_d_ff <= dclk_s;
      push_ff <= 1'b0;
      if (conv_go)
      begin
        conv_busy_ff <= 1'b1;
        conv_cnt_ff <= 16'h0000;
        busy_n <= 1'b0;
      end
      else if (conv_busy_ff)
      begin
        if (conv_cnt_ff == CONV_LAST)
        begin
          conv_busy_ff <= 1'b0;
          result_ff <= sar_code;
          push_ff <= 1'b1;
          busy_n <= 1'b1;
        end
        else
          conv_cnt_ff <= conv_cnt_ff + 16'h0001;
      end
    end
  end

  // serial readout, internal burst or external clocked read
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= ST_IDLE;
      tcnt_ff <= 5'h00;
      bitcnt_ff <= 5'h00;
      tx_sr_ff <= 16'h0000;
      tag_lat_ff <= 1'b0;
      seen_ff <= 1'b0;
      sync_pend_ff <= 1'b0;
      shown_ff <= 1'b0;
      frame_sync <= 1'b0;
      serial_data <= 1'b0;
      data_shift_clock_out <= 1'b0;
      data_shift_clock_oe <= 1'b0;
    end
    else
    begin
      data_shift_clock_oe <= !ext_mode;
      serial_data <= shown_ff ? tx_sr_ff[15] : tag_lat_ff;
      case (st_ff)
        ST_IDLE:
        begin
          data_shift_clock_out <= 1'b0;
          frame_sync <= 1'b0;
          if (!ext_mode && conv_go)
          begin
            tx_sr_ff <= tx_word;
            tag_lat_ff <= tag_s;
            shown_ff <= 1'b1;
            tcnt_ff <= TD4;
            bitcnt_ff <= 5'h00;
            st_ff <= ST_IWAIT;
          end
          else if (ext_mode && rd_rise)
          begin
            tx_sr_ff <= tx_word;
            tag_lat_ff <= tag_s;
            shown_ff <= 1'b0;
            sync_pend_ff <= seen_ff;
            seen_ff <= 1'b0;
            st_ff <= ST_XRD;
          end
          else if (ext_mode && dclk_rise && !rd_sel)
            seen_ff <= 1'b1;
        end
        ST_IWAIT:
        begin
          if (tcnt_ff == 5'h00)
          begin
            data_shift_clock_out <= 1'b1;
            tcnt_ff <= HALF;
            st_ff <= ST_IHI;
          end
          else
            tcnt_ff <= tcnt_ff - 5'h01;
        end
        ST_IHI:
        begin
          if (tcnt_ff == 5'h00)
          begin
            // bit changes after the falling edge, valid on both edges
            data_shift_clock_out <= 1'b0;
            tx_sr_ff <= {tx_sr_ff[14:0], tag_lat_ff};
            bitcnt_ff <= bitcnt_ff + 5'h01;
            tcnt_ff <= HALF;
            if (bitcnt_ff == `SADC_BITS_PER_WORD - 5'h01)
              st_ff <= ST_IDLE;
            else
              st_ff <= ST_ILO;
          end
          else
            tcnt_ff <= tcnt_ff - 5'h01;
        end
        ST_ILO:
        begin
          if (tcnt_ff == 5'h00)
          begin
            data_shift_clock_out <= 1'b1;
            tcnt_ff <= HALF;
            st_ff <= ST_IHI;
          end
          else
            tcnt_ff <= tcnt_ff - 5'h01;
        end
        ST_XRD:
        begin
          data_shift_clock_out <= 1'b0;
          if (!rd_sel || !ext_mode)
          begin
            frame_sync <= 1'b0;
            st_ff <= ST_IDLE;
          end
          else if (dclk_rise)
          begin
            if (sync_pend_ff)
            begin
              frame_sync <= 1'b1;
              sync_pend_ff <= 1'b0;
            end
            else
            begin
              frame_sync <= 1'b0;
              if (!shown_ff)
                shown_ff <= 1'b1;
              else
                tx_sr_ff <= {tx_sr_ff[14:0], tag_s};
            end
          end
        end
        default:
          st_ff <= ST_IDLE;
      endcase
    end
  end
endmodule

// ---- sim/sadc_ctrl_assertions.sv ----
`timescale 1ns/100ps
`include "sadc_regs.vh"
module sadc_ctrl_assertions #(
  parameter CONV_CYCLES = 300
)
(
  input wire mclk,
  input wire resetn,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire read_convert,
  input wire dev_select_n,
  input wire data_shift_clock_out,
  input wire data_shift_clock_oe,
  input wire frame_sync,
  input wire busy_n
);
  integer low_ff;
  logic [4:0] pulse_ff;
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_ff <= 0;
      pulse_ff <= 5'h00;
    end
    else
    begin
      low_ff <= busy_n ? 0 : low_ff + 1;
      if ($fell(busy_n))
        pulse_ff <= 5'h00;
      else if ($rose(data_shift_clock_out))
        pulse_ff <= pulse_ff + 5'h01;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  a_rd_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_err_rdata:
    assert property (s_axi_rvalid && s_axi_rresp == `SADC_RESP_SLVERR
      |-> s_axi_rdata == 32'h00000000) else $error("error read data");
  a_busy_len:
    assert property ($rose(busy_n) |-> low_ff == CONV_CYCLES)
      else $error("busy length");
  a_burst_count:
    assert property ($rose(busy_n) && data_shift_clock_oe
      |-> pulse_ff == 5'h10) else $error("burst pulse count");
  a_clk_idle:
    assert property (data_shift_clock_oe && busy_n && $past(busy_n)
      |-> !data_shift_clock_out) else $error("clock not idle low");
  a_sync_ext:
    assert property (frame_sync |-> !data_shift_clock_oe)
      else $error("sync in internal mode");
  a_start_cause:
    assert property ($fell(busy_n) |-> $past(!dev_select_n, 2)
      && $past(!read_convert, 2)) else $error("start without cause");
  a_pin_sync:
    assert property ($fell(read_convert) && busy_n |=> busy_n)
      else $error("start before sync");
endmodule

bind sadc_ctrl sadc_ctrl_assertions #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .mclk(mclk), .resetn(resetn), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .read_convert(read_convert),
  .dev_select_n(dev_select_n), .data_shift_clock_out(data_shift_clock_out),
  .data_shift_clock_oe(data_shift_clock_oe), .frame_sync(frame_sync),
  .busy_n(busy_n));

// ---- sim/sadc_host_model.sv ----
`timescale 1ns/100ps
module sadc_host_model
(
  input wire pin_clk,
  input wire serial_data,
  input wire frame_sync,
  output logic host_clk
);
  logic [31:0] rx = 32'h00000000;
  int n = 0;
  int fs = 0;
  initial
    host_clk = 1'b0;
  // k clock pulses on request, also outside a frame; low otherwise
  task automatic pulses(input int k);
    repeat (k)
    begin
      #40 host_clk = 1'b1;
      #40 host_clk = 1'b0;
    end
  endtask
  always @(posedge pin_clk)
  begin
    rx <= {rx[30:0], serial_data};
    n <= n + 1;
    if (frame_sync)
      fs <= fs + 1;
  end
endmodule

// ---- sim/sar_adc_serial_readout_control_tb_top.sv ----
`timescale 1ns/100ps
`include "sadc_regs.vh"
module sar_adc_serial_readout_control_tb_top;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic rc = 1'b1, cs_n = 1'b1, tag = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic [11:0] code = 12'h000;
  logic awr, wrd, bv, arr, rv, clko, oe, sd, fs, busy_n, hclk;
  logic [1:0] br, rr, resp;
  logic [31:0] rdat, rd;
  wire pin = oe ? clko : hclk;
  int num_errors = 0;
  int num_checks = 0;

  always #5 mclk = ~mclk;

  sadc_ctrl #(.CONV_CYCLES(300)) DUT (.mclk(mclk), .resetn(resetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .read_convert(rc),
    .dev_select_n(cs_n), .cascade_in(tag), .data_shift_clock_in(pin),
    .data_shift_clock_out(clko), .data_shift_clock_oe(oe),
    .serial_data(sd), .frame_sync(fs), .busy_n(busy_n), .sar_code(code));
  sadc_host_model u_host (.pin_clk(pin), .serial_data(sd),
    .frame_sync(fs), .host_clk(hclk));

  task automatic chk(input logic [31:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do @(posedge mclk); while (!awr);
    awv <= 1'b0;
    wv <= 1'b0;
    while (!bv) @(posedge mclk);
    resp = br;
    bry <= 1'b0;
    @(posedge mclk);
  endtask

  // rready raised late so the slave must hold its answer
  task automatic rdr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    do @(posedge mclk); while (!arr);
    arv <= 1'b0;
    @(posedge mclk);
    rry <= 1'b1;
    do @(posedge mclk); while (!rv);
    rd = rdat;
    resp = rr;
    rry <= 1'b0;
    @(posedge mclk);
  endtask

  // rc_last drops convert last, otherwise select falls last
  task automatic conv(input logic starts, input logic rc_last);
    cs_n <= !rc_last;
    rc <= rc_last;
    repeat (5) @(posedge mclk);
    cs_n <= 1'b0;
    rc <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(busy_n, !starts, "busy");
    rc <= 1'b1;
    for (int i = 0; i < 400 && !busy_n; i++) @(posedge mclk);
    @(posedge mclk);
  endtask

  task automatic xread(input int k, input int f);
    repeat (8) @(posedge mclk);
    u_host.n = 0;
    u_host.fs = 0;
    #3;
    u_host.pulses(k);
    chk(u_host.rx[16:1], 16'h7C50, "ext word");
    chk(u_host.rx[0], 1'b1, "tag level");
    chk(u_host.fs, f, "sync count");
    @(posedge mclk);
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rdr(`SADC_CTRL_OFS);
    chk(rd, 32'h00000000, "ctrl reset");
    rdr(8'h0C);
    chk(resp, `SADC_RESP_SLVERR, "unmapped resp");
    chk(oe, 1'b1, "clock out");
    wr(8'h0C, 32'h00000007);
    chk(resp, `SADC_RESP_SLVERR, "unmapped write resp");
    rdr(`SADC_CTRL_OFS);
    chk(rd, 32'h00000000, "ctrl kept");
    for (int i = 0; i < 9; i++)
    begin
      code <= {i[3:0], 8'hC5};
      u_host.n = 0;
      conv(i < 8, i[0]);
      if (i > 0 && i < 8)
      begin
        chk(u_host.rx[15:0], {4'(i - 1) ^ 4'h8, 12'hC50}, "burst");
        chk(u_host.n, 16, "pulses");
        chk(sd, 1'b1, "idle tag");
      end
    end
    rdr(`SADC_STAT_OFS);
    chk(rd[3], 1'b1, "full");
    for (int i = 0; i < 9; i++)
    begin
      rdr(`SADC_RSLT_OFS);
      chk(rd[16], i < 8, "valid");
      if (i < 8)
        chk(rd[11:0], {i[3:0], 8'hC5}, "result");
    end
    rdr(`SADC_STAT_OFS);
    chk(rd[2], 1'b1, "empty");
    wr(`SADC_CTRL_OFS, 32'h00000005);
    chk(resp, `SADC_RESP_OKAY, "write resp");
    rdr(`SADC_CTRL_OFS);
    chk(rd, 32'h00000005, "ctrl write");
    chk(oe, 1'b0, "clock in");
    cs_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #3;
    u_host.pulses(1);
    @(posedge mclk);
    cs_n <= 1'b0;
    xread(19, 1);
    wr(`SADC_CTRL_OFS, 32'h00000007);
    conv(1'b0, 1'b0);
    xread(18, 0);
    final_report;
  end

  initial
  begin
    #300000;
    num_errors++;
    final_report;
  end
endmodule
